// ==== flash_prog_pkg.sv ====
package flash_prog_pkg;

  // Clock and timing base
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned RC_KHZ = 7370;
  localparam int unsigned ACC_W = 17;

  // Operation lengths in internal RC oscillator cycles
  localparam int unsigned ROW_TICKS = 11064;
  localparam int unsigned WORD_TICKS = 400;
  localparam int unsigned PAGE_TICKS = 2000;
  localparam int unsigned BULK_TICKS = 4000;
  localparam int unsigned CFG_TICKS = 400;

  // Extra bus wait on a table write, so it spans three cycles instead of two
  localparam logic [1:0] TW_EXTRA = 2'h1;

  // Register byte offsets
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_PAGE = 8'h08;
  localparam logic [7:0] OFS_EA = 8'h0c;
  localparam logic [7:0] OFS_TWL = 8'h10;
  localparam logic [7:0] OFS_TWH = 8'h14;
  localparam logic [7:0] OFS_TRL = 8'h18;
  localparam logic [7:0] OFS_TRH = 8'h1c;
  localparam logic [7:0] OFS_STAT = 8'h20;

  // Control register fields
  localparam int unsigned START_BIT = 15;
  localparam int unsigned PERMIT_BIT = 14;
  localparam int unsigned ERR_BIT = 13;
  localparam int unsigned ERASE_BIT = 6;
  localparam int unsigned OPC_MSB = 3;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [15:0] EA_RST = 16'h0000;

  // Unlock sequence
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // Operation codes
  localparam logic [3:0] OPC_BULK = 4'hf;
  localparam logic [3:0] OPC_SEG = 4'hd;
  localparam logic [3:0] OPC_PAGE = 4'h2;
  localparam logic [3:0] OPC_CFG = 4'h0;
  localparam logic [3:0] OPC_WORD = 4'h3;
  localparam logic [3:0] OPC_ROW = 4'h1;

  // Array geometry; addresses step by two per word
  localparam int unsigned ROW_WORDS = 64;
  localparam int unsigned ROWS_PER_PAGE = 8;
  localparam int unsigned IDX_W = $clog2(ROW_WORDS);
  localparam int unsigned ROW_LSB = IDX_W + 1;
  localparam int unsigned PAGE_LSB = $clog2(ROW_WORDS * ROWS_PER_PAGE) + 1;

  typedef enum logic [2:0] {
    OP_NONE, OP_BULK, OP_SEGMENT, OP_PAGE, OP_CFG_ERASE, OP_WORD, OP_ROW, OP_CFG_PROG
  } op_kind_t;

  typedef enum logic {ST_IDLE, ST_RUN} seq_state_t;

  typedef struct packed {
    logic valid;
    op_kind_t kind;
    logic [23:0] addr;
  } flash_cmd_t;

  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic [23:0] data;
  } flash_wr_t;

endpackage

// ==== flash_self_program_ctrl.sv ====
`timescale 1ns/1ps

module flash_self_program_ctrl #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned ROW_TICKS = flash_prog_pkg::ROW_TICKS,
  parameter int unsigned WORD_TICKS = flash_prog_pkg::WORD_TICKS,
  parameter int unsigned PAGE_TICKS = flash_prog_pkg::PAGE_TICKS,
  parameter int unsigned BULK_TICKS = flash_prog_pkg::BULK_TICKS,
  parameter int unsigned CFG_TICKS = flash_prog_pkg::CFG_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [flash_prog_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic stall_o,
  output logic [23:0] flash_raddr_o,
  input wire logic [23:0] flash_rdata_i,
  output flash_prog_pkg::flash_cmd_t flash_cmd_o,
  output flash_prog_pkg::flash_wr_t flash_wr_o,
  input wire logic serial_prog_clock_pin_i,
  input wire logic serial_prog_data_pin_i,
  output logic serial_prog_data_pin_o,
  output logic serial_prog_data_pin_oe_n_o,
  input wire logic master_clear_pin_n_i,
  output logic serial_prog_active_o,
  output logic serial_prog_clock_o,
  output logic serial_prog_data_o
);

  localparam int unsigned IW = flash_prog_pkg::IDX_W;

  flash_prog_pkg::seq_state_t state_r;
  flash_prog_pkg::op_kind_t kind_r;
  flash_prog_pkg::op_kind_t kind_nxt;
  flash_prog_pkg::flash_cmd_t cmd_r;
  flash_prog_pkg::flash_wr_t wr_r;

  logic [23:0] hold_buf [flash_prog_pkg::ROW_WORDS];

  logic ack_r;
  logic [1:0] wait_r;
  logic [31:0] dat_r;
  logic req;
  logic go;
  logic wr;
  logic rd;
  logic busy;
  logic hit_ctrl;
  logic hit_key;
  logic hit_page;
  logic hit_ea;
  logic hit_twl;
  logic hit_twh;
  logic hit_trl;
  logic hit_trh;
  logic hit_stat;
  logic byte_mode;

  logic start_r;
  logic permit_r;
  logic err_r;
  logic erase_r;
  logic [3:0] opc_r;
  logic permit_nxt;
  logic erase_nxt;
  logic [3:0] opc_nxt;
  logic key_first_r;
  logic armed_r;
  logic start_try;
  logic start_ok;
  logic launch;
  logic done;
  logic abort;

  logic [7:0] page_r;
  logic [15:0] ea_r;
  logic [23:0] prog_addr;
  logic [IW-1:0] buf_idx;

  logic [23:0] base_r;
  logic [CNT_W-1:0] rem_r;
  logic [IW:0] left_r;
  logic [IW-1:0] idx_r;
  logic [flash_prog_pkg::ACC_W-1:0] acc_r;
  logic [flash_prog_pkg::ACC_W-1:0] acc_sum;
  logic rc_tick;

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;

  function automatic flash_prog_pkg::op_kind_t decode(input logic erase, input logic [3:0] opc);
    decode = flash_prog_pkg::OP_NONE;
    if (erase) begin
      case (opc)
        flash_prog_pkg::OPC_BULK: decode = flash_prog_pkg::OP_BULK;
        flash_prog_pkg::OPC_SEG: decode = flash_prog_pkg::OP_SEGMENT;
        flash_prog_pkg::OPC_PAGE: decode = flash_prog_pkg::OP_PAGE;
        flash_prog_pkg::OPC_CFG: decode = flash_prog_pkg::OP_CFG_ERASE;
        default: decode = flash_prog_pkg::OP_NONE;
      endcase
    end else begin
      case (opc)
        flash_prog_pkg::OPC_WORD: decode = flash_prog_pkg::OP_WORD;
        flash_prog_pkg::OPC_ROW: decode = flash_prog_pkg::OP_ROW;
        flash_prog_pkg::OPC_CFG: decode = flash_prog_pkg::OP_CFG_PROG;
        default: decode = flash_prog_pkg::OP_NONE;
      endcase
    end
  endfunction

  function automatic logic [CNT_W-1:0] ticks(input flash_prog_pkg::op_kind_t kind);
    case (kind)
      flash_prog_pkg::OP_ROW: ticks = CNT_W'(ROW_TICKS);
      flash_prog_pkg::OP_WORD: ticks = CNT_W'(WORD_TICKS);
      flash_prog_pkg::OP_PAGE: ticks = CNT_W'(PAGE_TICKS);
      flash_prog_pkg::OP_BULK: ticks = CNT_W'(BULK_TICKS);
      flash_prog_pkg::OP_SEGMENT: ticks = CNT_W'(BULK_TICKS);
      flash_prog_pkg::OP_CFG_ERASE: ticks = CNT_W'(CFG_TICKS);
      flash_prog_pkg::OP_CFG_PROG: ticks = CNT_W'(CFG_TICKS);
      default: ticks = '0;
    endcase
  endfunction

  // Bus decode
  assign hit_ctrl = wb_adr_i == flash_prog_pkg::OFS_CTRL;
  assign hit_key = wb_adr_i == flash_prog_pkg::OFS_KEY;
  assign hit_page = wb_adr_i == flash_prog_pkg::OFS_PAGE;
  assign hit_ea = wb_adr_i == flash_prog_pkg::OFS_EA;
  assign hit_twl = wb_adr_i == flash_prog_pkg::OFS_TWL;
  assign hit_twh = wb_adr_i == flash_prog_pkg::OFS_TWH;
  assign hit_trl = wb_adr_i == flash_prog_pkg::OFS_TRL;
  assign hit_trh = wb_adr_i == flash_prog_pkg::OFS_TRH;
  assign hit_stat = wb_adr_i == flash_prog_pkg::OFS_STAT;
  assign byte_mode = wb_sel_i[1:0] == 2'h1;

  assign busy = state_r == flash_prog_pkg::ST_RUN;
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  // Bus held off while busy, and stall_o stalls the core from the first busy cycle, access or not
  assign go = req & ~busy & (~(wb_we_i & (hit_twl | hit_twh))
              | wait_r == flash_prog_pkg::TW_EXTRA);
  assign wr = go & wb_we_i;
  assign rd = go & ~wb_we_i;
  assign stall_o = busy;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      wait_r <= 2'h0;
    end else begin
      ack_r <= go;
      if (go) begin
        wait_r <= 2'h0;
      end else if (req & ~busy & wb_we_i) begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
  assign wb_ack_o = ack_r;

  // Read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= '0;
    end else if (rd) begin
      dat_r <= '0;
      if (hit_ctrl) begin
        dat_r[flash_prog_pkg::START_BIT] <= start_r;
        dat_r[flash_prog_pkg::PERMIT_BIT] <= permit_r;
        dat_r[flash_prog_pkg::ERR_BIT] <= err_r;
        dat_r[flash_prog_pkg::ERASE_BIT] <= erase_r;
        dat_r[flash_prog_pkg::OPC_MSB:0] <= opc_r;
      end
      if (hit_page) begin
        dat_r[7:0] <= page_r;
      end
      if (hit_ea) begin
        dat_r[15:0] <= ea_r;
      end
      if (hit_trl) begin
        if (byte_mode) begin
          dat_r[7:0] <= ea_r[0] ? flash_rdata_i[15:8] : flash_rdata_i[7:0];
        end else begin
          dat_r[15:0] <= flash_rdata_i[15:0];
        end
      end
      // Upper byte of the high word is a phantom and reads as zero
      if (hit_trh & ~(byte_mode & ea_r[0])) begin
        dat_r[7:0] <= flash_rdata_i[23:16];
      end
      if (hit_stat) begin
        dat_r[1:0] <= {armed_r, sync2_r[2]};
      end
      // Key register and unmapped offsets read zero
    end
  end
  assign wb_dat_o = dat_r;

  // Table pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_r <= flash_prog_pkg::PAGE_RST;
      ea_r <= flash_prog_pkg::EA_RST;
    end else if (wr) begin
      if (hit_page & wb_sel_i[0]) begin
        page_r <= wb_dat_i[7:0];
      end
      if (hit_ea) begin
        if (wb_sel_i[0]) begin
          ea_r[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          ea_r[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end
  assign prog_addr = {page_r, ea_r};
  assign flash_raddr_o = prog_addr;
  assign buf_idx = ea_r[IW:1];

  // Holding buffer; table writes never touch the array
  always_ff @(posedge clk_i) begin
    if (wr & hit_twl) begin
      if (byte_mode & ea_r[0]) begin
        hold_buf[buf_idx][15:8] <= wb_dat_i[7:0];
      end else if (byte_mode) begin
        hold_buf[buf_idx][7:0] <= wb_dat_i[7:0];
      end else begin
        hold_buf[buf_idx][15:0] <= wb_dat_i[15:0];
      end
    end
    if (wr & hit_twh & ~(byte_mode & ea_r[0])) begin
      hold_buf[buf_idx][23:16] <= wb_dat_i[7:0];
    end
  end

  // Unlock: any other write between the keys breaks the sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_first_r <= 1'b0;
      armed_r <= 1'b0;
    end else if (wr) begin
      key_first_r <= hit_key & wb_sel_i[0] & wb_dat_i[7:0] == flash_prog_pkg::KEY_FIRST;
      armed_r <= hit_key & wb_sel_i[0] & key_first_r
                 & wb_dat_i[7:0] == flash_prog_pkg::KEY_SECOND;
    end
  end

  assign permit_nxt = (wr & hit_ctrl & wb_sel_i[1]) ? wb_dat_i[flash_prog_pkg::PERMIT_BIT]
                      : permit_r;
  assign erase_nxt = (wr & hit_ctrl & wb_sel_i[0]) ? wb_dat_i[flash_prog_pkg::ERASE_BIT]
                     : erase_r;
  assign opc_nxt = (wr & hit_ctrl & wb_sel_i[0]) ? wb_dat_i[flash_prog_pkg::OPC_MSB:0] : opc_r;
  assign start_try = wr & hit_ctrl & wb_sel_i[1] & wb_dat_i[flash_prog_pkg::START_BIT];
  assign start_ok = armed_r & permit_nxt & ~sync2_r[2];
  assign launch = start_try & start_ok;
  assign kind_nxt = decode(erase_nxt, opc_nxt);
  assign abort = rst_i & busy;

  // Control fields survive every reset but power-on
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      permit_r <= flash_prog_pkg::CTRL_RST[flash_prog_pkg::PERMIT_BIT];
      erase_r <= flash_prog_pkg::CTRL_RST[flash_prog_pkg::ERASE_BIT];
      opc_r <= flash_prog_pkg::CTRL_RST[flash_prog_pkg::OPC_MSB:0];
    end else begin
      permit_r <= permit_nxt;
      erase_r <= erase_nxt;
      opc_r <= opc_nxt;
    end
  end

  // Start is set-only from the bus; a zero written to it is ignored
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      start_r <= flash_prog_pkg::CTRL_RST[flash_prog_pkg::START_BIT];
    end else if (launch) begin
      start_r <= 1'b1;
    end else if (done | abort) begin
      start_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      err_r <= flash_prog_pkg::CTRL_RST[flash_prog_pkg::ERR_BIT];
    end else if ((start_try & ~start_ok) | abort) begin
      err_r <= 1'b1;
    end else if (done) begin
      err_r <= 1'b0;
    end else if (wr & hit_ctrl & wb_sel_i[1]) begin
      err_r <= wb_dat_i[flash_prog_pkg::ERR_BIT];
    end
  end

  // Internal RC oscillator rate as a fractional enable
  assign acc_sum = acc_r + flash_prog_pkg::ACC_W'(flash_prog_pkg::RC_KHZ);
  assign rc_tick = acc_sum >= flash_prog_pkg::ACC_W'(flash_prog_pkg::CLK_KHZ);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= '0;
    end else if (rc_tick) begin
      acc_r <= acc_sum - flash_prog_pkg::ACC_W'(flash_prog_pkg::CLK_KHZ);
    end else begin
      acc_r <= acc_sum;
    end
  end

  // Completion waits for the buffer stream even with shortened counts
  assign done = busy & rem_r == '0 & left_r == '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= flash_prog_pkg::ST_IDLE;
      kind_r <= flash_prog_pkg::OP_NONE;
      base_r <= '0;
      rem_r <= '0;
    end else begin
      case (state_r)
        flash_prog_pkg::ST_IDLE: begin
          if (launch) begin
            state_r <= flash_prog_pkg::ST_RUN;
            kind_r <= kind_nxt;
            base_r <= prog_addr;
            rem_r <= ticks(kind_nxt);
          end
        end
        flash_prog_pkg::ST_RUN: begin
          if (done) begin
            state_r <= flash_prog_pkg::ST_IDLE;
          end else if (rc_tick & rem_r != '0) begin
            rem_r <= rem_r - CNT_W'(1);
          end
        end
        default: state_r <= flash_prog_pkg::ST_IDLE;
      endcase
    end
  end

  // Array command, issued once per real operation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_r <= '0;
    end else begin
      cmd_r.valid <= launch & kind_nxt != flash_prog_pkg::OP_NONE;
      cmd_r.kind <= kind_nxt;
      case (kind_nxt)
        flash_prog_pkg::OP_PAGE:
          cmd_r.addr <= (prog_addr >> flash_prog_pkg::PAGE_LSB) << flash_prog_pkg::PAGE_LSB;
        flash_prog_pkg::OP_ROW:
          cmd_r.addr <= (prog_addr >> flash_prog_pkg::ROW_LSB) << flash_prog_pkg::ROW_LSB;
        flash_prog_pkg::OP_WORD: cmd_r.addr <= {prog_addr[23:1], 1'b0};
        default: cmd_r.addr <= prog_addr;
      endcase
    end
  end
  assign flash_cmd_o = cmd_r;

  // Buffer stream to the array: whole row or the one addressed word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_r <= '0;
      idx_r <= '0;
      wr_r <= '0;
    end else begin
      wr_r.valid <= 1'b0;
      if (launch & kind_nxt == flash_prog_pkg::OP_ROW) begin
        left_r <= (IW + 1)'(flash_prog_pkg::ROW_WORDS);
        idx_r <= '0;
      end else if (launch & (kind_nxt == flash_prog_pkg::OP_WORD
                             | kind_nxt == flash_prog_pkg::OP_CFG_PROG)) begin
        left_r <= (IW + 1)'(1);
        idx_r <= buf_idx;
      end else if (busy & left_r != '0) begin
        left_r <= left_r - (IW + 1)'(1);
        idx_r <= idx_r + IW'(1);
        wr_r.valid <= 1'b1;
        wr_r.addr <= {base_r[23:flash_prog_pkg::ROW_LSB], idx_r, 1'b0};
        wr_r.data <= hold_buf[idx_r];
      end
    end
  end
  assign flash_wr_o = wr_r;

  // Serial programming pins; the engine that speaks the protocol sits outside
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {~master_clear_pin_n_i, serial_prog_data_pin_i, serial_prog_clock_pin_i};
      sync2_r <= sync1_r;
    end
  end
  assign serial_prog_active_o = sync2_r[2];
  assign serial_prog_data_o = sync2_r[1];
  assign serial_prog_clock_o = sync2_r[0];
  // Pin stays released; answering the programmer belongs to the outside engine
  assign serial_prog_data_pin_o = 1'b0;
  assign serial_prog_data_pin_oe_n_o = 1'b1;

endmodule

// ==== flash_array_model.sv ====
`timescale 1ns/1ps
module flash_array_model (
  input wire logic clk_i,
  input wire logic [23:0] raddr_i,
  output logic [23:0] rdata_o,
  input flash_prog_pkg::flash_cmd_t cmd_i,
  input flash_prog_pkg::flash_wr_t wr_i
);
  logic [23:0] mem [logic [22:0]];
  int tick = 0;
  // Untouched words read a non-blank pattern so a missed erase shows up
  always @(raddr_i, tick) begin
    if (mem.exists(raddr_i[23:1])) begin
      rdata_o = mem[raddr_i[23:1]];
    end else begin
      rdata_o = raddr_i ^ 24'h5a5a5a;
    end
  end
  always @(posedge clk_i) begin
    if (wr_i.valid === 1'b1) begin
      mem[wr_i.addr[23:1]] = wr_i.data;
      tick++;
    end
    if (cmd_i.valid === 1'b1 && cmd_i.kind == flash_prog_pkg::OP_PAGE) begin
      for (int i = 0; i < 512; i++) begin
        mem[23'({cmd_i.addr[23:10], 9'h000} + i)] = 24'hffffff;
      end
      tick++;
    end
  end
endmodule

// ==== flash_ctrl_assertions.sv ====
`timescale 1ns/1ps
module flash_ctrl_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_we_i,
  input wire logic [flash_prog_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic stall_o,
  input wire logic [23:0] flash_rdata_i,
  input flash_prog_pkg::flash_cmd_t flash_cmd_o,
  input flash_prog_pkg::flash_wr_t flash_wr_o,
  input wire logic serial_prog_data_pin_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_no_ack_busy: assert property (stall_o && $past(stall_o) |-> !wb_ack_o)
    else $error("bus answered while core stalled");
  chk_cmd_stalls: assert property (flash_cmd_o.valid |-> stall_o [*8])
    else $error("operation launched without a long stall");
  chk_wr_busy: assert property (flash_wr_o.valid |-> stall_o)
    else $error("array written outside an operation");
  chk_page_align: assert property (flash_cmd_o.valid &&
    flash_cmd_o.kind == flash_prog_pkg::OP_PAGE |-> flash_cmd_o.addr[9:0] == 10'h000)
    else $error("page erase not page aligned");
  chk_row_align: assert property (flash_cmd_o.valid &&
    flash_cmd_o.kind == flash_prog_pkg::OP_ROW |-> flash_cmd_o.addr[6:0] == 7'h00)
    else $error("row program not row aligned");
  chk_row_step: assert property (flash_wr_o.valid && $past(flash_wr_o.valid)
    |-> flash_wr_o.addr == $past(flash_wr_o.addr) + 24'h000002)
    else $error("row words not consecutive");
  chk_key_zero: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == flash_prog_pkg::OFS_KEY |-> wb_dat_o == 32'h00000000)
    else $error("key register readable");
  chk_read_low: assert property (wb_ack_o && !wb_we_i && wb_sel_i == 4'hf &&
    wb_adr_i == flash_prog_pkg::OFS_TRL |-> wb_dat_o == {16'h0000, flash_rdata_i[15:0]})
    else $error("low table read wrong bits");
  chk_read_high: assert property (wb_ack_o && !wb_we_i && wb_sel_i == 4'hf &&
    wb_adr_i == flash_prog_pkg::OFS_TRH |-> wb_dat_o == {24'h000000, flash_rdata_i[23:16]})
    else $error("high table read wrong bits");
  chk_pin_released: assert property (serial_prog_data_pin_oe_n_o)
    else $error("serial data pin driven");
endmodule

bind flash_self_program_ctrl flash_ctrl_checker u_chk (.clk_i, .rst_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_o, .wb_ack_o, .stall_o, .flash_rdata_i, .flash_cmd_o, .flash_wr_o,
  .serial_prog_data_pin_oe_n_o);

// ==== flash_self_program_ctrl_tb.sv ====
`timescale 1ns/1ps
module flash_self_program_ctrl_tb;
  localparam int unsigned ROWT = 100;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic master_clear_pin_n_i = 1'b1;
  logic serial_prog_clock_pin_i = 1'b0;
  logic serial_prog_data_pin_i = 1'b0;
  logic serial_prog_data_pin_o, serial_prog_data_pin_oe_n_o;
  logic serial_prog_active_o, serial_prog_clock_o, serial_prog_data_o;
  logic [31:0] wb_dat_o, rv;
  logic wb_ack_o, stall_o;
  logic [23:0] flash_raddr_o, flash_rdata_i;
  flash_prog_pkg::flash_cmd_t flash_cmd_o;
  flash_prog_pkg::flash_wr_t flash_wr_o;
  logic [2:0] lastk;
  logic [15:0] c;
  int fail_count = 0, compares = 0, ncmd = 0, nst = 0, n, n0;
  logic [4:0] opc_tab [11] = '{5'h1f, 5'h1d, 5'h12, 5'h10, 5'h13, 5'h11, 5'h03, 5'h00,
    5'h0f, 5'h0d, 5'h02};
  // Enum positions of the expected operation, zero where the code does nothing
  logic [2:0] kind_tab [11] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0, 3'h5, 3'h7, 3'h0, 3'h0, 3'h0};

  always #5 clk_i = ~clk_i;

  flash_self_program_ctrl #(.ROW_TICKS(ROWT), .WORD_TICKS(20), .PAGE_TICKS(20),
    .BULK_TICKS(40), .CFG_TICKS(10)) dut (.clk_i, .rst_i, .por_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .stall_o, .flash_raddr_o,
    .flash_rdata_i, .flash_cmd_o, .flash_wr_o, .serial_prog_clock_pin_i,
    .serial_prog_data_pin_i, .serial_prog_data_pin_o, .serial_prog_data_pin_oe_n_o,
    .master_clear_pin_n_i, .serial_prog_active_o, .serial_prog_clock_o,
    .serial_prog_data_o);

  flash_array_model u_arr (.clk_i, .raddr_i(flash_raddr_o), .rdata_o(flash_rdata_i),
    .cmd_i(flash_cmd_o), .wr_i(flash_wr_o));

  always @(posedge clk_i) begin
    if (flash_cmd_o.valid === 1'b1) begin
      ncmd++;
      lastk = flash_cmd_o.kind;
    end
    if (stall_o === 1'b1) nst++;
  end

  task automatic complete_run;
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Wait on ack without a cycle limit; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, 4'hf);
    chk(nm, e, rv);
  endtask

  task automatic start(input logic [15:0] v);
    bus(1'b1, flash_prog_pkg::OFS_KEY, 32'h00000055, 4'h1);
    bus(1'b1, flash_prog_pkg::OFS_KEY, 32'h000000aa, 4'h1);
    bus(1'b1, flash_prog_pkg::OFS_CTRL, {16'h0000, v | 16'h8000}, 4'h3);
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    complete_run;
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    rdc("ctrl_reset", flash_prog_pkg::OFS_CTRL, 32'h00000000);
    rdc("key_read", flash_prog_pkg::OFS_KEY, 32'h00000000);
    rdc("unmapped", 8'h3c, 32'h00000000);
    wr(flash_prog_pkg::OFS_PAGE, 32'h00000001);
    wr(flash_prog_pkg::OFS_EA, 32'h00000080);
    chk("target_addr", 32'h00010080, {8'h00, flash_raddr_o});
    start(16'h0001);
    rdc("no_permit", flash_prog_pkg::OFS_CTRL, 32'h00002001);
    bus(1'b1, flash_prog_pkg::OFS_KEY, 32'h00000055, 4'h1);
    wr(flash_prog_pkg::OFS_PAGE, 32'h00000001);
    bus(1'b1, flash_prog_pkg::OFS_KEY, 32'h000000aa, 4'h1);
    bus(1'b1, flash_prog_pkg::OFS_CTRL, 32'h0000c001, 4'h3);
    rdc("broken_key", flash_prog_pkg::OFS_CTRL, 32'h00006001);
    for (int i = 0; i < 11; i++) begin
      c = 16'h4000 | {9'h000, opc_tab[i][4], 2'b00, opc_tab[i][3:0]};
      n0 = ncmd;
      wr(flash_prog_pkg::OFS_CTRL, {16'h0000, c});
      start(c);
      rdc("op_done", flash_prog_pkg::OFS_CTRL, {16'h0000, c});
      chk("cmd_count", n0 + (kind_tab[i] != 3'h0), ncmd);
      if (kind_tab[i] != 3'h0) chk("cmd_kind", {29'h0, kind_tab[i]}, {29'h0, lastk});
    end
    for (int i = 0; i < 64; i++) begin
      wr(flash_prog_pkg::OFS_EA, 32'h00000080 + 2 * i);
      wr(flash_prog_pkg::OFS_TWL, {16'h0000, 16'h1234 ^ 16'(i)});
      chk("tw_cycles", 3, n);
      wr(flash_prog_pkg::OFS_TWH, {24'h000000, 8'h40 + 8'(i)});
    end
    wr(flash_prog_pkg::OFS_CTRL, 32'h00004001);
    nst = 0;
    start(16'h4001);
    rdc("row_done", flash_prog_pkg::OFS_CTRL, 32'h00004001);
    chk("row_time", 1, nst >= ROWT * 13 && nst <= ROWT * 14 + 80);
    for (int i = 0; i < 64; i++) begin
      wr(flash_prog_pkg::OFS_EA, 32'h00000080 + 2 * i);
      rdc("row_low", flash_prog_pkg::OFS_TRL, {16'h0000, 16'h1234 ^ 16'(i)});
      rdc("row_high", flash_prog_pkg::OFS_TRH, {24'h000000, 8'h40 + 8'(i)});
    end
    wr(flash_prog_pkg::OFS_EA, 32'h00000081);
    bus(1'b0, flash_prog_pkg::OFS_TRL, 32'h00000000, 4'h1);
    chk("byte_read", 32'h00000012, rv);
    wr(flash_prog_pkg::OFS_EA, 32'h00000200);
    rdc("erased", flash_prog_pkg::OFS_TRL, 32'h0000ffff);
    wr(flash_prog_pkg::OFS_CTRL, 32'h0000404f);
    start(16'h404f);
    repeat (30) @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("abort", flash_prog_pkg::OFS_CTRL, 32'h0000604f);
    por_i <= 1'b1;
    @(posedge clk_i);
    por_i <= 1'b0;
    rdc("por_clear", flash_prog_pkg::OFS_CTRL, 32'h00000000);
    n0 = ncmd;
    wr(flash_prog_pkg::OFS_KEY, 32'h00000055);
    wr(flash_prog_pkg::OFS_KEY, 32'h000000aa);
    wr(flash_prog_pkg::OFS_CTRL, 32'h00004001);
    chk("zero_start", n0, ncmd);
    rdc("zero_start_ctrl", flash_prog_pkg::OFS_CTRL, 32'h00004001);
    chk("pin_data_idle", 32'h0, {31'h0, serial_prog_data_o});
    master_clear_pin_n_i <= 1'b0;
    serial_prog_clock_pin_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("serial_active_o", 32'h1, {31'h0, serial_prog_active_o});
    chk("serial_clock_o", 32'h1, {31'h0, serial_prog_clock_o});
    chk("serial_data_o", 32'h0, {31'h0, serial_prog_data_o});
    chk("pin_data_out", 32'h0, {31'h0, serial_prog_data_pin_o});
    chk("pin_oe_n", 32'h1, {31'h0, serial_prog_data_pin_oe_n_o});
    serial_prog_data_pin_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("serial_data_hi", 32'h1, {31'h0, serial_prog_data_o});
    rdc("serial_active", flash_prog_pkg::OFS_STAT, 32'h00000001);
    start(16'h4001);
    rdc("serial_block", flash_prog_pkg::OFS_CTRL, 32'h00006001);
    master_clear_pin_n_i <= 1'b1;
    complete_run;
  end
endmodule
